// ==== logic/hc_flags_pkg.sv ====
package hc_flags_pkg;

  // ***********************************************************
  // register map
  // ***********************************************************
  localparam logic [7:0] OFS_FLAGS_SET = 8'h50;
  localparam logic [7:0] OFS_FLAGS_CLR = 8'h54;

  localparam int BIT_ROM_VALID   = 31;
  localparam int BIT_SWAP_DIS    = 30;
  localparam int BIT_LATE_ACK    = 29;
  localparam int BIT_ENH_OWN     = 23;
  localparam int BIT_LINK_ON     = 17;

  localparam logic RST_ROM_VALID = 1'b0;
  localparam logic RST_SWAP_DIS  = 1'b0;
  localparam logic RST_LATE_ACK  = 1'b0;
  localparam logic RST_ENH_OWN   = 1'b1;

  // ***********************************************************
  // acknowledge codes
  // ***********************************************************
  typedef enum logic [1:0]
  {
    ACK_NORMAL,
    ACK_TYPE_ERROR,
    ACK_LATE
  } ack_kind_e;

  // ***********************************************************
  // carriers
  // ***********************************************************
  typedef struct packed
  {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_s;

  typedef struct packed
  {
    logic valid;
    logic rom_block_read;
    logic to_own_node;
  } bus_req_s;

endpackage : hc_flags_pkg

// ==== logic/host_ctrl_upper_flags.sv ====
`timescale 1ns/1ns
// How it works
// - valid rom image lets block reads of config rom be answered normally.
// - without valid rom image, config rom block reads get ack_type_error.
// - bus reset with image invalid keeps rom mapping, header, options unchanged.
// - valid flag cleared by hardware reset, software reset or fetch error.
// - swap disable bit steers byte swapping of dma and physical data.
// - late-ack permit makes other node-addressed async packets get ack_tardy.
// - every ack_tardy sent pulses the ack_tardy event to interrupt logic.
// - bits 28 to 24 always read as zero.
// - ownership flag read-only, resets to 1, loaded from eeprom at init.
// - link off means no packets received, processed or transmitted.
// - register reached at a set address and a clear address, both readable.
module host_ctrl_upper_flags
  import hc_flags_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire reg_req_s    reg_req,
  output logic [31:0]      rdata_ff,
  input  wire logic        soft_reset,
  input  wire logic        fetch_error,
  input  wire logic        link_on,
  input  wire logic        eeprom_load,
  input  wire logic        eeprom_enh_own,
  input  wire logic        bus_reset,
  input  wire bus_req_s    bus_req,
  output logic             ack_valid_ff,
  output ack_kind_e        ack_kind_ff,
  output logic             ack_tardy_event_ff,
  output logic             rom_regs_update_ff,
  output logic             rom_image_valid_ff,
  output logic             byte_swap_en_ff,
  output logic             late_ack_permit_ff
);

  // ***********************************************************
  // decode
  // ***********************************************************
  logic byte_swap_disable_ff;
  logic enhancement_ownership_ff;
  logic nxt_rom_image_valid;
  logic nxt_byte_swap_disable;
  logic nxt_late_ack_permit;
  logic nxt_enh_own;
  logic [31:0] flags_view;
  ack_kind_e nxt_ack_kind;

  wire hit_set = reg_req.wr && (reg_req.addr == OFS_FLAGS_SET);
  wire hit_clr = reg_req.wr && (reg_req.addr == OFS_FLAGS_CLR);
  wire hit_rd  = reg_req.rd && ((reg_req.addr == OFS_FLAGS_SET) ||
                 (reg_req.addr == OFS_FLAGS_CLR));

  // strobes come in as arguments so the assigns wake on every change
  function automatic logic set_clr(input logic cur,
                                   input logic set_hit,
                                   input logic clr_hit,
                                   input logic wbit);
    set_clr = (cur | (set_hit & wbit)) & ~(clr_hit & wbit);
  endfunction : set_clr

  // valid flag cannot be cleared by software, only by hardware events
  assign nxt_rom_image_valid = (soft_reset || fetch_error) ? 1'b0 :
    (rom_image_valid_ff | (hit_set & reg_req.wdata[BIT_ROM_VALID]));
  assign nxt_byte_swap_disable = set_clr(byte_swap_disable_ff, hit_set,
    hit_clr, reg_req.wdata[BIT_SWAP_DIS]);
  assign nxt_late_ack_permit = soft_reset ? 1'b0 :
    set_clr(late_ack_permit_ff, hit_set, hit_clr,
            reg_req.wdata[BIT_LATE_ACK]);
  assign nxt_enh_own = eeprom_load ? eeprom_enh_own :
                       enhancement_ownership_ff;

  // link bit lives elsewhere; mirrored so software can see it
  assign flags_view = {rom_image_valid_ff, byte_swap_disable_ff,
                       late_ack_permit_ff, 5'h00,
                       enhancement_ownership_ff, 5'h00, link_on,
                       17'h00000};

  // late ack wins only for traffic not aimed at config rom
  assign nxt_ack_kind =
    (bus_req.rom_block_read && !rom_image_valid_ff) ? ACK_TYPE_ERROR :
    (bus_req.rom_block_read) ? ACK_NORMAL :
    (late_ack_permit_ff && bus_req.to_own_node) ? ACK_LATE :
    ACK_NORMAL;

  wire take_req = bus_req.valid && link_on;

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rom_image_valid_ff       <= RST_ROM_VALID;
      byte_swap_disable_ff     <= RST_SWAP_DIS;
      late_ack_permit_ff       <= RST_LATE_ACK;
      enhancement_ownership_ff <= RST_ENH_OWN;
      rdata_ff                 <= 32'h00000000;
      ack_valid_ff             <= 1'b0;
      ack_kind_ff              <= ACK_NORMAL;
      ack_tardy_event_ff       <= 1'b0;
      rom_regs_update_ff       <= 1'b0;
      byte_swap_en_ff          <= 1'b1;
    end
    else
    begin
      rom_image_valid_ff       <= nxt_rom_image_valid;
      byte_swap_disable_ff     <= nxt_byte_swap_disable;
      late_ack_permit_ff       <= nxt_late_ack_permit;
      enhancement_ownership_ff <= nxt_enh_own;
      rdata_ff                 <= hit_rd ? flags_view : 32'h00000000;
      ack_valid_ff             <= take_req;
      ack_kind_ff              <= take_req ? nxt_ack_kind : ACK_NORMAL;
      ack_tardy_event_ff       <= take_req &&
                                  (nxt_ack_kind == ACK_LATE);
      rom_regs_update_ff       <= bus_reset && rom_image_valid_ff;
      byte_swap_en_ff          <= ~nxt_byte_swap_disable;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  // single- and multi-cycle behaviours, used by the checks below
  sequence s_late_req;
    take_req && late_ack_permit_ff && bus_req.to_own_node &&
    !bus_req.rom_block_read;
  endsequence
  sequence s_late_armed;
    hit_set && reg_req.wdata[BIT_LATE_ACK] && !soft_reset ##1
    !(hit_clr && reg_req.wdata[BIT_LATE_ACK]) && !soft_reset;
  endsequence
  sequence s_read_after_arm;
    s_late_armed ##1 hit_rd;
  endsequence
  sequence s_valid_held;
    rom_image_valid_ff && !soft_reset && !fetch_error;
  endsequence

  a_rom_error_ack: assert property (@(posedge clk_sys) disable iff (rst)
    bus_req.valid && link_on && bus_req.rom_block_read &&
    !rom_image_valid_ff |=> ack_valid_ff && ack_kind_ff == ACK_TYPE_ERROR)
    else $error("rom read not refused");
  a_rom_ok_ack: assert property (@(posedge clk_sys) disable iff (rst)
    bus_req.valid && link_on && bus_req.rom_block_read &&
    rom_image_valid_ff |=> ack_kind_ff == ACK_NORMAL)
    else $error("rom read refused");
  a_rom_no_update: assert property (@(posedge clk_sys) disable iff (rst)
    bus_reset && !rom_image_valid_ff |=> !rom_regs_update_ff)
    else $error("rom regs updated");
  a_valid_clears: assert property (@(posedge clk_sys) disable iff (rst)
    soft_reset || fetch_error |=> !rom_image_valid_ff)
    else $error("valid not cleared");
  a_swap_follows: assert property (@(posedge clk_sys) disable iff (rst)
    byte_swap_en_ff == !byte_swap_disable_ff)
    else $error("swap mismatch");
  a_late_ack: assert property (@(posedge clk_sys) disable iff (rst)
    s_late_req |=> ack_kind_ff == ACK_LATE)
    else $error("no late ack");
  a_tardy_event: assert property (@(posedge clk_sys) disable iff (rst)
    ack_tardy_event_ff == (ack_valid_ff && ack_kind_ff == ACK_LATE))
    else $error("tardy event mismatch");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    rdata_ff[28:24] == 5'h00)
    else $error("reserved bits set");
  a_own_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !eeprom_load && !$past(rst) |=> $stable(enhancement_ownership_ff))
    else $error("ownership changed");
  a_link_off: assert property (@(posedge clk_sys) disable iff (rst)
    !link_on |=> !ack_valid_ff)
    else $error("ack while link off");
  a_set_bit: assert property (@(posedge clk_sys) disable iff (rst)
    hit_set && reg_req.wdata[BIT_SWAP_DIS] |=> byte_swap_disable_ff)
    else $error("set failed");
  a_read_pair: assert property (@(posedge clk_sys) disable iff (rst)
    hit_rd |=> rdata_ff[BIT_ROM_VALID] == $past(rom_image_valid_ff))
    else $error("read wrong");
  a_tardy_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    s_late_req |=> ack_tardy_event_ff && ack_valid_ff)
    else $error("tardy event missing");
  a_set_then_read: assert property (@(posedge clk_sys) disable iff (rst)
    s_read_after_arm |=> rdata_ff[BIT_LATE_ACK])
    else $error("set bit not read back");
  a_clear_bit: assert property (@(posedge clk_sys) disable iff (rst)
    hit_clr && reg_req.wdata[BIT_LATE_ACK] |=> !late_ack_permit_ff)
    else $error("clear failed");
  a_zero_noop: assert property (@(posedge clk_sys) disable iff (rst)
    hit_set && !reg_req.wdata[BIT_SWAP_DIS] |=>
    $stable(byte_swap_disable_ff))
    else $error("zero write changed flag");
  a_valid_sticky: assert property (@(posedge clk_sys) disable iff (rst)
    s_valid_held |=> rom_image_valid_ff)
    else $error("valid dropped by software");
  a_own_readonly: assert property (@(posedge clk_sys) disable iff (rst)
    (hit_set || hit_clr) && !eeprom_load |=>
    $stable(enhancement_ownership_ff))
    else $error("ownership written");
  a_own_load: assert property (@(posedge clk_sys) disable iff (rst)
    eeprom_load |=> enhancement_ownership_ff == $past(eeprom_enh_own))
    else $error("ownership not loaded");
  a_rom_update: assert property (@(posedge clk_sys) disable iff (rst)
    bus_reset && rom_image_valid_ff |=> rom_regs_update_ff)
    else $error("rom regs not updated");
  a_rom_no_late: assert property (@(posedge clk_sys) disable iff (rst)
    take_req && bus_req.rom_block_read |=> ack_kind_ff != ACK_LATE)
    else $error("rom read got late ack");
  a_read_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !hit_rd |=> rdata_ff == 32'h00000000)
    else $error("read data without read");
  a_read_link: assert property (@(posedge clk_sys) disable iff (rst)
    hit_rd |=> rdata_ff[BIT_LINK_ON] == $past(link_on))
    else $error("link bit wrong");
  a_link_no_event: assert property (@(posedge clk_sys) disable iff (rst)
    !link_on |=> !ack_tardy_event_ff)
    else $error("event while link off");
  a_swap_clear: assert property (@(posedge clk_sys) disable iff (rst)
    hit_clr && reg_req.wdata[BIT_SWAP_DIS] |=> byte_swap_en_ff)
    else $error("swap not enabled");

endmodule : host_ctrl_upper_flags

// ==== test/remote_node.sv ====
`timescale 1ns/1ns
// ****************************************
// remote node: async requests to our node
// ****************************************
module remote_node
  import hc_flags_pkg::*;
(
  input  wire logic send,
  input  wire logic rom_read,
  input  wire logic own_node,
  output bus_req_s  bus_req
);
  // qualifiers drop to 0 outside a request, no stale address class
  assign bus_req = '{valid: send, rom_block_read: rom_read & send,
                     to_own_node: own_node & send};
endmodule : remote_node

// ==== test/test_host_ctrl_upper_flags.sv ====
`timescale 1ns/1ns
module test_host_ctrl_upper_flags
  import hc_flags_pkg::*;
;
  logic clk_sys = 0, rst = 1, link_on = 0, eeprom_enh_own = 1;
  logic soft_reset = 0, fetch_error = 0, eeprom_load = 0, bus_reset = 0;
  logic send = 0, rom_read = 0, own_node = 0;
  reg_req_s reg_req = '0;
  bus_req_s bus_req;
  logic [31:0] rdata_ff;
  ack_kind_e ack_kind_ff;
  logic ack_valid_ff, ack_tardy_event_ff, rom_regs_update_ff;
  logic rom_image_valid_ff, byte_swap_en_ff, late_ack_permit_ff;
  int failures = 0, checks = 0, cycles = 0;
  // write addr, write data, read addr, expected read
  logic [79:0] rows [5] = '{
    {8'h50, 32'hFFFF_FFFF, 8'h54, 32'hE080_0000},
    {8'h54, 32'h6000_0000, 8'h50, 32'h8080_0000},
    {8'h54, 32'h8080_0000, 8'h50, 32'h8080_0000},
    {8'h50, 32'h0000_0000, 8'h54, 32'h8080_0000},
    {8'h58, 32'hFFFF_FFFF, 8'h58, 32'h0000_0000}};
  always #10 clk_sys = ~clk_sys;
  remote_node peer (.send(send), .rom_read(rom_read), .own_node(own_node),
                    .bus_req(bus_req));
  host_ctrl_upper_flags dut (.clk_sys(clk_sys), .rst(rst), .reg_req(reg_req),
    .rdata_ff(rdata_ff), .soft_reset(soft_reset), .fetch_error(fetch_error),
    .link_on(link_on), .eeprom_load(eeprom_load),
    .eeprom_enh_own(eeprom_enh_own), .bus_reset(bus_reset),
    .bus_req(bus_req), .ack_valid_ff(ack_valid_ff), .ack_kind_ff(ack_kind_ff),
    .ack_tardy_event_ff(ack_tardy_event_ff),
    .rom_regs_update_ff(rom_regs_update_ff),
    .rom_image_valid_ff(rom_image_valid_ff),
    .byte_swap_en_ff(byte_swap_en_ff),
    .late_ack_permit_ff(late_ack_permit_ff));
  task report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task cmp_word(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp_word
  task cmp_flag(input logic g, input logic e);
    cmp_word({31'h0, g}, {31'h0, e});
  endtask : cmp_flag
  task reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) reg_req <= {1'b1, 1'b0, a, d};
    @(posedge clk_sys) reg_req <= '0;
  endtask : reg_wr
  task reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys) reg_req <= {1'b0, 1'b1, a, 32'h0};
    @(posedge clk_sys) reg_req <= '0;
    @(negedge clk_sys) cmp_word(rdata_ff, e);
  endtask : reg_rd
  // strobe order: eeprom_load, bus_reset, fetch_error, soft_reset
  task strobe(input logic [3:0] m);
    @(posedge clk_sys) {eeprom_load, bus_reset, fetch_error, soft_reset} <= m;
    @(posedge clk_sys)
      {eeprom_load, bus_reset, fetch_error, soft_reset} <= 4'h0;
    @(negedge clk_sys);
  endtask : strobe
  task bus(input logic r, o, v, input logic [1:0] k, input logic t);
    @(posedge clk_sys) {send, rom_read, own_node} <= {1'b1, r, o};
    @(posedge clk_sys) send <= 1'b0;
    @(negedge clk_sys) cmp_flag(ack_valid_ff, v);
    if (v)
      cmp_word({30'h0, ack_kind_ff}, {30'h0, k});
    cmp_flag(ack_tardy_event_ff, t);
  endtask : bus
  // hang guard, whole run is under a hundred cycles
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys) cmp_flag(byte_swap_en_ff, 1'b1);
    reg_rd(8'h50, 32'h0080_0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      reg_wr(rows[i][79:72], rows[i][71:40]);
      reg_rd(rows[i][39:32], rows[i][31:0]);
      cmp_flag(byte_swap_en_ff, ~rows[i][30]);
    end
    $display("register rows done");
    @(posedge clk_sys) link_on <= 1'b1;
    reg_wr(8'h50, 32'h2000_0000);
    reg_rd(8'h50, 32'hA082_0000);
    bus(1, 0, 1, ACK_NORMAL, 0);
    bus(0, 1, 1, ACK_LATE, 1);
    bus(0, 1, 1, ACK_LATE, 1);
    @(posedge clk_sys) link_on <= 1'b0;
    bus(1, 1, 0, ACK_NORMAL, 0);
    strobe(4'h4);
    cmp_flag(rom_regs_update_ff, 1'b1);
    strobe(4'h2);
    cmp_flag(rom_image_valid_ff, 1'b0);
    @(posedge clk_sys) link_on <= 1'b1;
    bus(1, 0, 1, ACK_TYPE_ERROR, 0);
    strobe(4'h4);
    cmp_flag(rom_regs_update_ff, 1'b0);
    @(posedge clk_sys) link_on <= 1'b0;
    reg_wr(8'h50, 32'h8000_0000);
    strobe(4'h1);
    cmp_flag(rom_image_valid_ff, 1'b0);
    cmp_flag(late_ack_permit_ff, 1'b0);
    $display("bus test done");
    @(posedge clk_sys) eeprom_enh_own <= 1'b0;
    strobe(4'h8);
    reg_rd(8'h54, 32'h0000_0000);
    $display("eeprom test done");
    report_and_stop();
  end
endmodule : test_host_ctrl_upper_flags
